// >>> core/aaops_alu.sv
// Notes on behaviour
// RULE1 - add immediate sets carry, nibble carry, zero
// RULE2 - and immediate updates accumulator and Z
// RULE3 - add register to accumulator; carry, nibble, zero
// RULE4 - and accumulator with register, Z only
// RULE5 - destination bit picks accumulator or register
// RULE6 - one instruction cycle of four clocks
// RULE7 - carry bit7, nibble carry bit3, zero
`timescale 1ns/100ps
`default_nettype none
`include "aaops_cfg.svh"
module aaops_alu (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [13:0] instr,
   input wire logic instr_valid,
   input wire logic [7:0] reg_rdata,
   output logic [6:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wen,
   output logic [7:0] acc,
   output logic carry_flag,
   output logic nibble_overflow_flag,
   output logic zero_flag,
   output logic cycle_end,
   output logic done,
   output aaops_pkg::aaops_op_t op_kind
);
   import aaops_pkg::*;
   aaops_state_t st_r;
   aaops_state_t st_nxt;
   logic [7:0] opnd;
   logic [4:0] lo_sum;
   logic [8:0] sum;
   logic [7:0] res;
   logic to_reg;

   aaops_phase u_phase (
      .clock(clock),
      .rst_n(rst_n),
      .cycle_end(cycle_end)
   );

   always_comb begin
      op_kind = AAOPS_NONE;
      if (instr[13:12] == `AAOPS_GRP_LIT) begin
         if (instr[11:9] == `AAOPS_OP_ADD_IMM_TOP) begin
            op_kind = AAOPS_ADD_IMM; // see RULE1
         end else if (instr[11:8] == `AAOPS_OP_AND_IMM) begin
            op_kind = AAOPS_AND_IMM; // see RULE2
         end
      end else if (instr[13:12] == `AAOPS_GRP_BYTE) begin
         if (instr[11:8] == `AAOPS_OP_ADD_REG) begin
            op_kind = AAOPS_ADD_REG; // see RULE3
         end else if (instr[11:8] == `AAOPS_OP_AND_REG) begin
            op_kind = AAOPS_AND_REG; // see RULE4
         end
      end
   end

   // read address follows the word; the decoder must hold it through write-back
   assign reg_addr = instr[6:0];
   assign to_reg = instr[`AAOPS_DEST_BIT];
   // register source only for byte forms; literal otherwise
   assign opnd = (op_kind == AAOPS_ADD_REG || op_kind == AAOPS_AND_REG) ?
      reg_rdata : instr[7:0];
   assign lo_sum = {1'b0, st_r.acc[3:0]} + {1'b0, opnd[3:0]}; // see RULE7
   assign sum = {1'b0, st_r.acc} + {1'b0, opnd}; // see RULE7

   always_comb begin
      st_nxt = st_r;
      st_nxt.wen = 1'b0;
      st_nxt.done = 1'b0;
      res = 8'h00;
      // work is done once per instruction cycle, at its last phase
      if (cycle_end && instr_valid && op_kind != AAOPS_NONE) begin // see RULE6
         st_nxt.done = 1'b1;
         if (op_kind == AAOPS_ADD_IMM || op_kind == AAOPS_ADD_REG) begin
            res = sum[7:0];
            st_nxt.carry = sum[8]; // see RULE7
            st_nxt.nibble = lo_sum[4]; // see RULE7
         end else begin
            res = st_r.acc & opnd; // see RULE2
         end
         st_nxt.zero = (res == 8'h00); // see RULE7
         if ((op_kind == AAOPS_ADD_REG || op_kind == AAOPS_AND_REG) && to_reg) begin
            st_nxt.wen = 1'b1; // see RULE5
            st_nxt.wdata = res;
            st_nxt.waddr = instr[6:0];
         end else begin
            st_nxt.acc = res; // see RULE5
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '{acc: `AAOPS_ACC_RESET, carry: 1'b0, nibble: 1'b0, zero: 1'b0,
                   wdata: 8'h00, waddr: 7'h00, wen: 1'b0, done: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign acc = st_r.acc;
   assign carry_flag = st_r.carry;
   assign nibble_overflow_flag = st_r.nibble;
   assign zero_flag = st_r.zero;
   assign reg_wdata = st_r.wdata;
   assign reg_wen = st_r.wen;
   assign done = st_r.done;

   // result checks rebuild each value from the operands, not from the adder nets
   property p_cycle_len;
      @(posedge clock) disable iff (!rst_n)
         cycle_end |=> !cycle_end [*3] ##1 cycle_end;
   endproperty
   a_cycle_len: assert property (p_cycle_len) else $error("cycle not four clocks"); // see RULE6

   property p_add_imm;
      @(posedge clock) disable iff (!rst_n)
         (cycle_end && instr_valid && op_kind == AAOPS_ADD_IMM)
         |=> {carry_flag, acc} == $past({1'b0, st_r.acc} + {1'b0, instr[7:0]});
   endproperty
   a_add_imm: assert property (p_add_imm) else $error("add immediate wrong"); // see RULE1

   property p_and_imm;
      @(posedge clock) disable iff (!rst_n)
         (cycle_end && instr_valid && op_kind == AAOPS_AND_IMM)
         |=> acc == ($past(st_r.acc) & $past(instr[7:0])) && $stable(carry_flag)
             && $stable(nibble_overflow_flag);
   endproperty
   a_and_imm: assert property (p_and_imm) else $error("and immediate wrong"); // see RULE2

   property p_add_reg_w;
      @(posedge clock) disable iff (!rst_n)
         (cycle_end && instr_valid && op_kind == AAOPS_ADD_REG && !to_reg)
         |=> acc == $past(st_r.acc + reg_rdata) && !reg_wen;
   endproperty
   a_add_reg_w: assert property (p_add_reg_w) else $error("add register wrong"); // see RULE3

   property p_and_reg;
      @(posedge clock) disable iff (!rst_n)
         (cycle_end && instr_valid && op_kind == AAOPS_AND_REG)
         |=> $stable(carry_flag) && $stable(nibble_overflow_flag);
   endproperty
   a_and_reg: assert property (p_and_reg) else $error("and register touched carry"); // see RULE4

   property p_dest_reg;
      @(posedge clock) disable iff (!rst_n)
         (cycle_end && instr_valid && (op_kind == AAOPS_ADD_REG || op_kind == AAOPS_AND_REG)
          && to_reg) |=> reg_wen && $stable(acc) && reg_addr == $past(instr[6:0]) ##1 !reg_wen;
   endproperty
   a_dest_reg: assert property (p_dest_reg) else $error("register write-back wrong"); // see RULE5

   property p_nibble;
      @(posedge clock) disable iff (!rst_n)
         (cycle_end && instr_valid && op_kind == AAOPS_ADD_IMM)
         |=> nibble_overflow_flag
             == $past(({1'b0, st_r.acc[3:0]} + {1'b0, instr[3:0]}) > 5'h0F);
   endproperty
   a_nibble: assert property (p_nibble) else $error("nibble carry wrong"); // see RULE7

   property p_zero;
      @(posedge clock) disable iff (!rst_n)
         done && !reg_wen |-> zero_flag == (acc == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong"); // see RULE7

   property p_zero_wb;
      @(posedge clock) disable iff (!rst_n)
         reg_wen |-> zero_flag == (reg_wdata == 8'h00);
   endproperty
   a_zero_wb: assert property (p_zero_wb) else $error("write-back zero wrong"); // see RULE7

   property p_wb_addr;
      @(posedge clock) disable iff (!rst_n)
         reg_wen |-> reg_addr == st_r.waddr;
   endproperty
   a_wb_addr: assert property (p_wb_addr) else $error("write-back address moved"); // see RULE5

   property p_carry_reg;
      @(posedge clock) disable iff (!rst_n)
         (cycle_end && instr_valid && op_kind == AAOPS_ADD_REG)
         |=> {carry_flag, (reg_wen ? reg_wdata : acc)}
             == $past({1'b0, st_r.acc} + {1'b0, reg_rdata});
   endproperty
   a_carry_reg: assert property (p_carry_reg) else $error("add carry wrong"); // see RULE3

   property p_nibble_reg;
      @(posedge clock) disable iff (!rst_n)
         (cycle_end && instr_valid && op_kind == AAOPS_ADD_REG)
         |=> nibble_overflow_flag
             == $past(({1'b0, st_r.acc[3:0]} + {1'b0, reg_rdata[3:0]}) > 5'h0F);
   endproperty
   a_nibble_reg: assert property (p_nibble_reg) else $error("nibble carry wrong"); // see RULE7

   property p_and_reg_data;
      @(posedge clock) disable iff (!rst_n)
         (cycle_end && instr_valid && op_kind == AAOPS_AND_REG)
         |=> (reg_wen ? reg_wdata : acc) == $past(st_r.acc & reg_rdata);
   endproperty
   a_and_reg_data: assert property (p_and_reg_data) else $error("and data wrong"); // see RULE4

   property p_idle;
      @(posedge clock) disable iff (!rst_n)
         !(cycle_end && instr_valid && op_kind != AAOPS_NONE)
         |=> !done && !reg_wen && $stable(acc) && $stable(zero_flag)
             && $stable(carry_flag) && $stable(nibble_overflow_flag);
   endproperty
   a_idle: assert property (p_idle) else $error("refused word changed state"); // see RULE6

   property p_done_pulse;
      @(posedge clock) disable iff (!rst_n)
         done |=> !done;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done held too long"); // see RULE6

   property p_and_imm_zero;
      @(posedge clock) disable iff (!rst_n)
         (cycle_end && instr_valid && op_kind == AAOPS_AND_IMM)
         |=> zero_flag == ($past(st_r.acc & instr[7:0]) == 8'h00);
   endproperty
   a_and_imm_zero: assert property (p_and_imm_zero) else $error("and zero wrong"); // see RULE2
endmodule
`default_nettype wire

// >>> core/aaops_cfg.svh
`ifndef AAOPS_CFG_SVH
`define AAOPS_CFG_SVH
// add immediate ignores the lowest opcode bit, so only the top three are decoded
`define AAOPS_OP_ADD_IMM_TOP 3'h7
`define AAOPS_OP_AND_IMM 4'h9
`define AAOPS_OP_ADD_REG 4'h7
`define AAOPS_OP_AND_REG 4'h5
`define AAOPS_GRP_LIT 2'h3
`define AAOPS_GRP_BYTE 2'h0
`define AAOPS_PHASES 2'h3
`define AAOPS_DEST_BIT 7
`define AAOPS_ACC_RESET 8'h00
`endif

// >>> core/aaops_phase.sv
`timescale 1ns/100ps
`default_nettype none
`include "aaops_cfg.svh"
module aaops_phase (
   input wire logic clock,
   input wire logic rst_n,
   output logic cycle_end
);
   import aaops_pkg::*;
   aaops_phase_t ph_r;
   aaops_phase_t ph_nxt;
   // four oscillator periods make one instruction cycle; it never stalls
   always_comb begin
      ph_nxt = ph_r;
      ph_nxt.count = ph_r.count + 2'h1; // see RULE6
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ph_r <= '{count: 2'h0};
      end else begin
         ph_r <= ph_nxt;
      end
   end
   assign cycle_end = (ph_r.count == `AAOPS_PHASES); // see RULE6
endmodule
`default_nettype wire

// >>> core/aaops_pkg.sv
package aaops_pkg;
   typedef enum logic [2:0] {
      AAOPS_NONE,
      AAOPS_ADD_IMM,
      AAOPS_AND_IMM,
      AAOPS_ADD_REG,
      AAOPS_AND_REG
   } aaops_op_t;
   typedef struct packed {
      logic [7:0] acc;
      logic carry;
      logic nibble;
      logic zero;
      logic [7:0] wdata;
      logic [6:0] waddr;
      logic wen;
      logic done;
   } aaops_state_t;
   typedef struct packed {
      logic [1:0] count;
   } aaops_phase_t;
endpackage

// >>> dv/aaops_regfile_model.sv
`timescale 1ns/100ps
`default_nettype none
module aaops_regfile_model (
   input wire logic clock,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wen,
   output logic [7:0] reg_rdata
);
   logic [7:0] mem [0:127];
   // read is combinational; the core relies on it within the same clock
   assign reg_rdata = mem[reg_addr];
   always @(posedge clock) begin
      if (reg_wen) begin
         mem[reg_addr] <= reg_wdata;
      end
   end
endmodule
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [13:0] instr = 14'h0000;
   logic instr_valid = 1'b0;
   wire logic [7:0] reg_rdata, reg_wdata, acc;
   wire logic [6:0] reg_addr;
   wire logic reg_wen, cf, nf, zf, cycle_end, done;
   aaops_pkg::aaops_op_t kind;
   int errors = 0;
   int compares = 0;
   logic [7:0] acc_m = 8'h00;
   logic c_m = 1'b0;
   logic nc_m = 1'b0;
   logic z_m = 1'b0;
   always #5 clock = ~clock;
   aaops_alu u_aaops_alu (.clock(clock), .rst_n(rst_n), .instr(instr),
      .instr_valid(instr_valid), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wen(reg_wen), .acc(acc), .carry_flag(cf),
      .nibble_overflow_flag(nf), .zero_flag(zf), .cycle_end(cycle_end),
      .done(done), .op_kind(kind));
   aaops_regfile_model u_aaops_regfile_model (.clock(clock), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wen(reg_wen), .reg_rdata(reg_rdata));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one instruction; expectation built before the taken edge
   task automatic run(input logic [13:0] w, input logic v);
      logic [7:0] b, r;
      logic [8:0] s;
      logic [4:0] h;
      logic ad, rg, ex, wb;
      int n;
      aaops_pkg::aaops_op_t k;
      n = 0;
      while (cycle_end !== 1'b1 && n < 8) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk({7'h00, cycle_end}, 8'h01);
      instr = w;
      instr_valid = v;
      ad = (w[13:9] == 5'h1F) || (w[13:8] == 6'h07);
      rg = (w[13:8] == 6'h07) || (w[13:8] == 6'h05);
      ex = v && (ad || rg || w[13:8] == 6'h39);
      wb = ex && rg && w[7];
      b = rg ? u_aaops_regfile_model.mem[w[6:0]] : w[7:0];
      s = {1'b0, acc_m} + {1'b0, b};
      h = {1'b0, acc_m[3:0]} + {1'b0, b[3:0]};
      r = ad ? s[7:0] : (acc_m & b);
      k = aaops_pkg::AAOPS_NONE;
      case (w[13:8])
         6'h3E, 6'h3F: k = aaops_pkg::AAOPS_ADD_IMM;
         6'h39: k = aaops_pkg::AAOPS_AND_IMM;
         6'h07: k = aaops_pkg::AAOPS_ADD_REG;
         6'h05: k = aaops_pkg::AAOPS_AND_REG;
         default: k = aaops_pkg::AAOPS_NONE;
      endcase
      if (ex) begin
         z_m = (r == 8'h00);
         if (ad) begin
            c_m = s[8];
            nc_m = h[4];
         end
         if (!wb) begin
            acc_m = r;
         end
      end
      @(posedge clock);
      #1;
      instr_valid = 1'b0;
      chk({7'h00, done}, {7'h00, ex});
      chk(acc, acc_m);
      chk({5'h00, cf, nf, zf}, {5'h00, c_m, nc_m, z_m});
      chk({7'h00, reg_wen}, {7'h00, wb});
      chk({5'h00, kind}, {5'h00, k});
      chk({1'b0, reg_addr}, {1'b0, w[6:0]});
      if (wb) begin
         chk(reg_wdata, r);
      end
      @(posedge clock);
      #1;
      chk({7'h00, done}, 8'h00);
      if (wb) begin
         chk(u_aaops_regfile_model.mem[w[6:0]], r);
      end
   endtask
   task automatic t_add_imm();
      run(14'h3E15, 1'b1);
      run(14'h3FEB, 1'b1);
   endtask
   task automatic t_and_imm();
      run(14'h395F, 1'b1);
      run(14'h3EA3, 1'b1);
      run(14'h395C, 1'b1);
   endtask
   task automatic t_add_reg();
      run(14'h3E17, 1'b1);
      run(14'h077F, 1'b1);
      run(14'h07FF, 1'b1);
      run(14'h0780, 1'b1);
   endtask
   task automatic t_and_reg();
      run(14'h057F, 1'b1);
      run(14'h05FF, 1'b1);
      run(14'h0581, 1'b1);
   endtask
   // reset in mid-run clears the accumulator, every flag and all three pulses
   task automatic t_reset();
      rst_n = 1'b0;
      acc_m = 8'h00;
      c_m = 1'b0;
      nc_m = 1'b0;
      z_m = 1'b0;
      @(posedge clock);
      #1;
      chk(acc, acc_m);
      chk({5'h00, cf, nf, zf}, 8'h00);
      chk({5'h00, done, reg_wen, cycle_end}, 8'h00);
      rst_n = 1'b1;
   endtask
   // ignored requests must leave every result alone
   task automatic t_refused();
      run(14'h3E01, 1'b0);
      run(14'h3A55, 1'b1);
      run(14'h1FFF, 1'b1);
   endtask
   task automatic give_verdict();
      if (errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      u_aaops_regfile_model.mem[127] = 8'hC2;
      u_aaops_regfile_model.mem[0] = 8'hF0;
      u_aaops_regfile_model.mem[1] = 8'h66;
      repeat (6) @(posedge clock);
      #1;
      rst_n = 1'b1;
      t_add_imm();
      t_and_imm();
      t_add_reg();
      t_and_reg();
      t_reset();
      t_refused();
      give_verdict();
   end
   initial begin
      #5000;
      errors++;
      give_verdict();
   end
endmodule
`default_nettype wire
